// ===== design/sccfg_pkg.sv
// Constants for the smart card configuration header upper registers
package sccfg_pkg;

  // Configuration address width (byte address, dword aligned access)
  localparam int CFG_AW = 8;

  // Dword addresses seen on the configuration port
  localparam logic [7:0] SCCFG_DW_SUBSYS = 8'h2c;
  localparam logic [7:0] SCCFG_DW_CAPPTR = 8'h34;
  localparam logic [7:0] SCCFG_DW_IRQ = 8'h3c;
  localparam logic [7:0] SCCFG_DW_CAPITEM = 8'h44;
  localparam logic [7:0] SCCFG_DW_SUBACC = 8'h50;
  localparam logic [7:0] SCCFG_DW_SYSCTL = 8'h80;

  // Printed byte offsets of the registers
  localparam logic [7:0] SCCFG_OFS_SUBSYS_IDENT = 8'h2e;
  localparam logic [7:0] SCCFG_OFS_CAP_POINTER = 8'h34;
  localparam logic [7:0] SCCFG_OFS_IRQ_LINE = 8'h3c;
  localparam logic [7:0] SCCFG_OFS_IRQ_PIN = 8'h3d;
  localparam logic [7:0] SCCFG_OFS_MIN_GRANT = 8'h3e;
  localparam logic [7:0] SCCFG_OFS_MAX_LATENCY = 8'h3f;
  localparam logic [7:0] SCCFG_OFS_CAP_ITEM = 8'h44;

  // Byte lane of each byte-wide field, and bit positions of the subsystem ident and tie-all, inside their dword
  localparam int SCCFG_LANE_IRQ_LINE = 0;
  localparam int SCCFG_LANE_IRQ_PIN = 1;
  localparam int SCCFG_LANE_MIN_GRANT = 2;
  localparam int SCCFG_LANE_MAX_LATENCY = 3;
  localparam int SCCFG_SUBSYS_LSB = 16;
  localparam int SCCFG_TIE_ALL_BIT = 28;

  // Fixed and reset values
  localparam logic [7:0] SCCFG_CAP_POINTER_VAL = 8'h44;
  localparam logic [7:0] SCCFG_IRQ_LINE_RST = 8'hff;
  localparam logic [7:0] SCCFG_MIN_GRANT_RST = 8'h07;
  localparam logic [7:0] SCCFG_MAX_LATENCY_RST = 8'h04;
  localparam logic [7:0] SCCFG_CAP_TYPE_CODE = 8'h01;
  localparam logic [7:0] SCCFG_CAP_NEXT_ITEM = 8'h00;
  localparam logic [15:0] SCCFG_SUBSYS_RST = 16'h0000;
  localparam logic [31:0] SCCFG_RDATA_NONE = 32'h0000_0000;

  // Interrupt pin codes
  localparam logic [7:0] SCCFG_PIN_INTA = 8'h01;
  localparam logic [7:0] SCCFG_PIN_INTB = 8'h02;
  localparam logic [7:0] SCCFG_PIN_INTC = 8'h03;
  localparam logic [7:0] SCCFG_PIN_INTD = 8'h04;

  // Number of interrupt tie-request lines
  localparam int SCCFG_TIE_LINES = 4;

endpackage

// ===== design/sccfg_irq_pin_dec.sv
// Interrupt pin code decoder with tie-request priority
module sccfg_irq_pin_dec
  import sccfg_pkg::*;
#(
  parameter int LINES = SCCFG_TIE_LINES
) (
  // Selection
  input wire logic [1:0] i_irq_select,
  input wire logic [LINES-1:0] i_tie_request_inputs,
  // Result
  output logic [7:0] o_irq_pin_code
);

  // Priority chain below is written for four lines only
  if (LINES != 4) begin : g_lines_check
    $error("sccfg_irq_pin_dec supports exactly four lines");
  end

  always_comb begin
    o_irq_pin_code = SCCFG_PIN_INTA;
    if (i_tie_request_inputs[0]) begin
      o_irq_pin_code = SCCFG_PIN_INTA;
    end else if (i_tie_request_inputs[1]) begin
      o_irq_pin_code = SCCFG_PIN_INTB;
    end else if (i_tie_request_inputs[2]) begin
      o_irq_pin_code = SCCFG_PIN_INTC;
    end else if (i_tie_request_inputs[3]) begin
      o_irq_pin_code = SCCFG_PIN_INTD;
    end else begin
      case (i_irq_select)
        2'h0: o_irq_pin_code = SCCFG_PIN_INTA;
        2'h1: o_irq_pin_code = SCCFG_PIN_INTB;
        2'h2: o_irq_pin_code = SCCFG_PIN_INTC;
        2'h3: o_irq_pin_code = SCCFG_PIN_INTD;
        default: o_irq_pin_code = SCCFG_PIN_INTA;
      endcase
    end
  end

endmodule // sccfg_irq_pin_dec

// ===== design/sccfg_header_regs.sv
// Smart card configuration header upper registers
//
// Functional notes
// - Subsystem ident is read-only at 2Ch, loaded from memory
// - Subsystem ident written through access register 50h
// - Subsystem ident cleared by global reset only
// - Capabilities pointer reads fixed 44h
// - Interrupt line read/write, resets to FFh
// - Pin code follows select when no tie
// - Asserted tie line overrides select by priority
// - Tie-all set asserts first tie line
// - Tie-all clear asserts no tie line
// - Minimum grant resets 07h, hardware updated
// - Maximum latency resets 04h, memory reloadable
// - Capability item low byte reads 01h
// - Capability item high byte reads 00h
module sccfg_header_regs
  import sccfg_pkg::*;
(
  // Clock and global reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Secondary reset source (function reset, not global)
  input wire logic i_func_rst,
  // Configuration access from the host
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [CFG_AW-1:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_unmapped,
  // Serial configuration memory load
  input wire logic i_eeprom_load,
  input wire logic [15:0] i_eeprom_subsys_ident,
  input wire logic [7:0] i_eeprom_max_latency,
  // Hardware update of minimum grant
  input wire logic i_min_grant_update,
  input wire logic [7:0] i_min_grant_value,
  // Interrupt selection
  input wire logic [1:0] i_irq_select,
  input wire logic [SCCFG_TIE_LINES-1:1] i_tie_request_inputs,
  // Register state
  output logic [15:0] o_subsys_ident,
  output logic [7:0] o_irq_line_assignment,
  output logic [7:0] o_irq_pin_code,
  output logic [7:0] o_min_bus_grant,
  output logic [7:0] o_max_bus_latency,
  output logic o_tie_all_control,
  output logic o_tie_request_first_line
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  ////////////////////////////////////////////////////////////////////////////

  logic rst_sync_a;
  logic rst_sync_b;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_a <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_sync_b <= rst_sync_a;
    end
  end

  assign rst_n = rst_sync_b;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] dw_addr;
  logic hit_subsys;
  logic hit_capptr;
  logic hit_irq;
  logic hit_capitem;
  logic hit_subacc;
  logic hit_sysctl;
  logic hit_any;
  logic wr_irq_line;
  logic wr_subacc_lo;
  logic wr_subacc_hi;
  logic wr_tie_all;

  // Accesses are dword aligned; low address bits are ignored
  assign dw_addr = {i_cfg_addr[7:2], 2'b00};
  assign hit_subsys = (dw_addr == SCCFG_DW_SUBSYS);
  assign hit_capptr = (dw_addr == SCCFG_DW_CAPPTR);
  assign hit_irq = (dw_addr == SCCFG_DW_IRQ);
  assign hit_capitem = (dw_addr == SCCFG_DW_CAPITEM);
  assign hit_subacc = (dw_addr == SCCFG_DW_SUBACC);
  assign hit_sysctl = (dw_addr == SCCFG_DW_SYSCTL);
  assign hit_any = hit_subsys | hit_capptr | hit_irq | hit_capitem
                 | hit_subacc | hit_sysctl;

  // Only these byte lanes take writes; all others drop the data
  assign wr_irq_line = i_cfg_wr & hit_irq
                     & i_cfg_be[SCCFG_LANE_IRQ_LINE];
  assign wr_subacc_lo = i_cfg_wr & hit_subacc & i_cfg_be[2];
  assign wr_subacc_hi = i_cfg_wr & hit_subacc & i_cfg_be[3];
  assign wr_tie_all = i_cfg_wr & hit_sysctl & i_cfg_be[3];

  ////////////////////////////////////////////////////////////////////////////
  // Subsystem identification
  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] subsys_ident;
  logic [15:0] next_subsys_ident;

  always_comb begin
    next_subsys_ident = subsys_ident;
    if (i_eeprom_load) begin
      next_subsys_ident = i_eeprom_subsys_ident;
    end
    // Software update wins over a concurrent memory load
    if (wr_subacc_lo) begin
      next_subsys_ident[7:0] =
        i_cfg_wdata[SCCFG_SUBSYS_LSB +: 8];
    end
    if (wr_subacc_hi) begin
      next_subsys_ident[15:8] =
        i_cfg_wdata[SCCFG_SUBSYS_LSB + 8 +: 8];
    end
  end

  // Only the global reset clears it; function reset is not applied
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_ident <= SCCFG_SUBSYS_RST;
    end else begin
      subsys_ident <= next_subsys_ident;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] irq_line;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line <= SCCFG_IRQ_LINE_RST;
    end else if (i_func_rst) begin
      irq_line <= SCCFG_IRQ_LINE_RST;
    end else if (wr_irq_line) begin
      irq_line <= i_cfg_wdata[8*SCCFG_LANE_IRQ_LINE +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System control tie-all
  ////////////////////////////////////////////////////////////////////////////

  logic tie_all;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tie_all <= 1'b0;
    end else if (i_func_rst) begin
      tie_all <= 1'b0;
    end else if (wr_tie_all) begin
      tie_all <= i_cfg_wdata[SCCFG_TIE_ALL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin decode
  ////////////////////////////////////////////////////////////////////////////

  logic [SCCFG_TIE_LINES-1:0] tie_vec;
  logic [7:0] pin_code;
  logic [7:0] irq_pin;

  // First line follows tie-all; with it clear none is driven here
  assign tie_vec[0] = tie_all;
  assign tie_vec[SCCFG_TIE_LINES-1:1] = i_tie_request_inputs;

  sccfg_irq_pin_dec #(
    .LINES(SCCFG_TIE_LINES)
  ) u_pin_dec (
    .i_irq_select(i_irq_select),
    .i_tie_request_inputs(tie_vec),
    .o_irq_pin_code(pin_code)
  );

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin <= SCCFG_PIN_INTA;
    end else begin
      irq_pin <= pin_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Minimum grant and maximum latency
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] min_grant;
  logic [7:0] max_latency;

  // Software writes to lanes 2 and 3 have no path here
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      min_grant <= SCCFG_MIN_GRANT_RST;
    end else if (i_min_grant_update) begin
      min_grant <= i_min_grant_value;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      max_latency <= SCCFG_MAX_LATENCY_RST;
    end else if (i_eeprom_load) begin
      max_latency <= i_eeprom_max_latency;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux
  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = SCCFG_RDATA_NONE;
    if (hit_subsys) begin
      rd_mux[SCCFG_SUBSYS_LSB +: 16] = subsys_ident;
    end else if (hit_capptr) begin
      rd_mux[7:0] = SCCFG_CAP_POINTER_VAL;
    end else if (hit_irq) begin
      rd_mux[8*SCCFG_LANE_IRQ_LINE +: 8] = irq_line;
      rd_mux[8*SCCFG_LANE_IRQ_PIN +: 8] = irq_pin;
      rd_mux[8*SCCFG_LANE_MIN_GRANT +: 8] = min_grant;
      rd_mux[8*SCCFG_LANE_MAX_LATENCY +: 8] = max_latency;
    end else if (hit_capitem) begin
      rd_mux[7:0] = SCCFG_CAP_TYPE_CODE;
      rd_mux[15:8] = SCCFG_CAP_NEXT_ITEM;
    end else if (hit_subacc) begin
      rd_mux[SCCFG_SUBSYS_LSB +: 16] = subsys_ident;
    end else if (hit_sysctl) begin
      rd_mux[SCCFG_TIE_ALL_BIT] = tie_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access answer
  ////////////////////////////////////////////////////////////////////////////

  logic cfg_req;

  assign cfg_req = i_cfg_rd | i_cfg_wr;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg_ack <= 1'b0;
      o_cfg_unmapped <= 1'b0;
    end else begin
      o_cfg_ack <= cfg_req;
      o_cfg_unmapped <= cfg_req & ~hit_any;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg_rdata <= SCCFG_RDATA_NONE;
    end else if (i_cfg_rd) begin
      o_cfg_rdata <= rd_mux;
    end else begin
      o_cfg_rdata <= SCCFG_RDATA_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State outputs
  ////////////////////////////////////////////////////////////////////////////

  // Mirrors keep every output straight from a flip-flop
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_subsys_ident <= SCCFG_SUBSYS_RST;
    end else begin
      o_subsys_ident <= next_subsys_ident;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_line_assignment <= SCCFG_IRQ_LINE_RST;
    end else if (i_func_rst) begin
      o_irq_line_assignment <= SCCFG_IRQ_LINE_RST;
    end else if (wr_irq_line) begin
      o_irq_line_assignment <= i_cfg_wdata[8*SCCFG_LANE_IRQ_LINE +: 8];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_pin_code <= SCCFG_PIN_INTA;
    end else begin
      o_irq_pin_code <= pin_code;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_min_bus_grant <= SCCFG_MIN_GRANT_RST;
    end else if (i_min_grant_update) begin
      o_min_bus_grant <= i_min_grant_value;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_max_bus_latency <= SCCFG_MAX_LATENCY_RST;
    end else if (i_eeprom_load) begin
      o_max_bus_latency <= i_eeprom_max_latency;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_tie_all_control <= 1'b0;
      o_tie_request_first_line <= 1'b0;
    end else if (i_func_rst) begin
      o_tie_all_control <= 1'b0;
      o_tie_request_first_line <= 1'b0;
    end else if (wr_tie_all) begin
      o_tie_all_control <= i_cfg_wdata[SCCFG_TIE_ALL_BIT];
      o_tie_request_first_line <= i_cfg_wdata[SCCFG_TIE_ALL_BIT];
    end
  end

endmodule // sccfg_header_regs

// ===== sim/sccfg_header_regs_assertions.sv
// Port checks for the configuration header upper registers
module sccfg_header_regs_assertions
  import sccfg_pkg::*;
(
  // Clock and resets
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_func_rst,
  // Configuration port
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [CFG_AW-1:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_unmapped,
  // Load and update
  input wire logic i_eeprom_load,
  input wire logic [15:0] i_eeprom_subsys_ident,
  input wire logic [7:0] i_eeprom_max_latency,
  input wire logic i_min_grant_update,
  input wire logic [7:0] i_min_grant_value,
  // Interrupt selection and state
  input wire logic [1:0] i_irq_select,
  input wire logic [SCCFG_TIE_LINES-1:1] i_tie_request_inputs,
  input wire logic [15:0] o_subsys_ident,
  input wire logic [7:0] o_irq_line_assignment,
  input wire logic [7:0] o_irq_pin_code,
  input wire logic [7:0] o_min_bus_grant,
  input wire logic [7:0] o_max_bus_latency,
  input wire logic o_tie_all_control,
  input wire logic o_tie_request_first_line
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [5:0] dw;
  logic sub_wr;
  assign dw = i_cfg_addr[7:2];
  assign sub_wr = i_cfg_wr && dw == SCCFG_DW_SUBACC[7:2];
  ////////////////////////////////////////////////////////////////////////
  AST_ACK: assert property ((i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
    else $error("request not acknowledged");
  AST_CAPPTR: assert property (
    i_cfg_rd && dw == SCCFG_DW_CAPPTR[7:2] |=> o_cfg_rdata == 32'h44)
    else $error("capabilities pointer wrong");
  AST_CAPITEM: assert property (
    i_cfg_rd && dw == SCCFG_DW_CAPITEM[7:2] |=> o_cfg_rdata == 32'h1)
    else $error("capability item wrong");
  AST_LINE_WR: assert property (
    i_cfg_wr && dw == SCCFG_DW_IRQ[7:2] && i_cfg_be[0] && !i_func_rst
    |=> o_irq_line_assignment == $past(i_cfg_wdata[7:0]))
    else $error("interrupt line write lost");
  AST_FRST: assert property (i_func_rst |=>
    o_irq_line_assignment == 8'hff && !o_tie_all_control)
    else $error("function reset missed");
  AST_SUB_KEEP: assert property (
    i_func_rst && !i_eeprom_load && !sub_wr |=> $stable(o_subsys_ident))
    else $error("function reset touched subsystem ident");
  AST_SUB_HOLD: assert property (
    !$stable(o_subsys_ident) |-> $past(i_eeprom_load || sub_wr))
    else $error("subsystem ident changed by itself");
  AST_LOAD: assert property (i_eeprom_load && !sub_wr |=>
    o_subsys_ident == $past(i_eeprom_subsys_ident)
    && o_max_bus_latency == $past(i_eeprom_max_latency))
    else $error("memory load lost");
  AST_SUBACC: assert property (
    sub_wr && i_cfg_be[3:2] == 2'b11
    |=> o_subsys_ident == $past(i_cfg_wdata[31:16]))
    else $error("subsystem access write lost");
  AST_MIN_GNT: assert property (i_min_grant_update
    |=> o_min_bus_grant == $past(i_min_grant_value))
    else $error("minimum grant update lost");
  AST_PIN_SEL: assert property (
    (i_tie_request_inputs == 3'h0 && !o_tie_request_first_line)[*3]
    |-> o_irq_pin_code == 8'h01 + {6'h00, $past(i_irq_select)})
    else $error("pin code does not follow select");
  AST_PIN_A: assert property (o_tie_request_first_line[*3]
    |-> o_irq_pin_code == SCCFG_PIN_INTA)
    else $error("tie-all pin code wrong");
  AST_PIN_B: assert property (
    (i_tie_request_inputs[1] && !o_tie_request_first_line)[*3]
    |-> o_irq_pin_code == SCCFG_PIN_INTB)
    else $error("tie priority wrong");
  AST_UNMAP: assert property (o_cfg_unmapped |->
    o_cfg_ack && o_cfg_rdata == 32'h0)
    else $error("unmapped answer wrong");
  cover property (o_cfg_unmapped);
  cover property (o_tie_request_first_line && i_cfg_rd);
  cover property (i_eeprom_load);
endmodule // sccfg_header_regs_assertions

bind sccfg_header_regs sccfg_header_regs_assertions u_chk (.*);

// ===== sim/sccfg_host_model.sv
// Host model issuing configuration read and write cycles
module sccfg_host_model (
  // Clock
  input wire logic i_mclk,
  // Requests
  output logic o_cfg_rd,
  output logic o_cfg_wr,
  output logic [7:0] o_cfg_addr,
  output logic [3:0] o_cfg_be,
  output logic [31:0] o_cfg_wdata,
  // Answer
  input wire logic i_cfg_ack,
  input wire logic [31:0] i_cfg_rdata,
  input wire logic i_cfg_unmapped
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cfg_rd = 1'b0;
    o_cfg_wr = 1'b0;
    o_cfg_addr = 8'h00;
    o_cfg_be = 4'h0;
    o_cfg_wdata = 32'h0;
  end
  // One-cycle request; afterwards strobes drop and address, enables and data show inverted values
  task automatic xfer(input logic r, input logic [7:0] a,
      input logic [3:0] b, input logic [31:0] w,
      output logic [31:0] d, output logic u, output logic k);
    @(posedge i_mclk);
    o_cfg_rd <= r;
    o_cfg_wr <= !r;
    o_cfg_addr <= a;
    o_cfg_be <= b;
    o_cfg_wdata <= w;
    @(posedge i_mclk);
    o_cfg_rd <= 1'b0;
    o_cfg_wr <= 1'b0;
    o_cfg_addr <= ~a;
    o_cfg_be <= ~b;
    o_cfg_wdata <= ~w;
    // Answer stands for the cycle after the request edge
    @(posedge i_mclk);
    d = i_cfg_rdata;
    u = i_cfg_unmapped;
    k = i_cfg_ack;
  endtask
endmodule // sccfg_host_model

// ===== sim/sccfg_header_regs_test.sv
// Self-checking bench for the configuration header registers
module sccfg_header_regs_test
  import sccfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic func_rst = 1'b0;
  logic rd, wr, ack, unm, k, u;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, d;
  logic ld = 1'b0;
  logic mgu = 1'b0;
  logic [15:0] esub = 16'h0;
  logic [7:0] eml = 8'h0;
  logic [7:0] mgv = 8'h0;
  logic [1:0] sel = 2'h0;
  logic [3:1] ties = 3'h0;
  logic [15:0] sub_q;
  logic [7:0] line_q, pin_q, mg_q, ml_q;
  logic tie_q, first_q;
  int fails = 0;
  int tests_run = 0;
  int m_line, m_sub, m_mg, m_ml, m_tie;
  logic [7:0] amap [7] = '{8'h2c, 8'h34, 8'h3c, 8'h44, 8'h50, 8'h80, 8'h60};
  always #10 mclk = ~mclk;
  sccfg_header_regs u_sccfg_header_regs (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_func_rst(func_rst),
    .i_cfg_rd(rd), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_be(be),
    .i_cfg_wdata(wdata), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
    .o_cfg_unmapped(unm), .i_eeprom_load(ld),
    .i_eeprom_subsys_ident(esub), .i_eeprom_max_latency(eml),
    .i_min_grant_update(mgu), .i_min_grant_value(mgv),
    .i_irq_select(sel), .i_tie_request_inputs(ties),
    .o_subsys_ident(sub_q), .o_irq_line_assignment(line_q),
    .o_irq_pin_code(pin_q), .o_min_bus_grant(mg_q),
    .o_max_bus_latency(ml_q), .o_tie_all_control(tie_q),
    .o_tie_request_first_line(first_q));
  sccfg_host_model u_host (
    .i_mclk(mclk), .o_cfg_rd(rd), .o_cfg_wr(wr), .o_cfg_addr(addr),
    .o_cfg_be(be), .o_cfg_wdata(wdata), .i_cfg_ack(ack),
    .i_cfg_rdata(rdata), .i_cfg_unmapped(unm));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] expd(logic [7:0] a);
    int p;
    p = m_tie ? 1 : ties[1] ? 2 : ties[2] ? 3 : ties[3] ? 4 : sel + 1;
    case (a)
      8'h2c, 8'h50: expd = {m_sub[15:0], 16'h0000};
      8'h34: expd = 32'h0000_0044;
      8'h3c: expd = {m_ml[7:0], m_mg[7:0], p[7:0], m_line[7:0]};
      8'h44: expd = 32'h0000_0001;
      8'h80: expd = m_tie << 28;
      default: expd = 32'h0000_0000;
    endcase
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic rdc(logic [7:0] a);
    logic [31:0] e;
    logic [31:0] f;
    u_host.xfer(1'b1, a, 4'h0, 32'h0, d, u, k);
    chk(d, expd(a));
    chk({31'h0, u}, {31'h0, a == 8'h60});
    chk({31'h0, k}, 32'h1);
    // State outputs against the model
    e = expd(8'h3c);
    f = {m_sub[15:0], m_line[7:0], e[15:8]};
    chk({sub_q, line_q, pin_q}, f);
    f = {m_mg[7:0], m_ml[7:0], 14'h0, m_tie[0], m_tie[0]};
    chk({mg_q, ml_q, 14'h0, tie_q, first_q}, f);
  endtask
  task automatic wrc(logic [7:0] a, logic [3:0] b, logic [31:0] w);
    u_host.xfer(1'b0, a, b, w, d, u, k);
    chk({31'h0, k}, 32'h1);
    if (a == 8'h3c && b[0]) m_line = w[7:0];
    if (a == 8'h50 && b[2]) m_sub[7:0] = w[23:16];
    if (a == 8'h50 && b[3]) m_sub[15:8] = w[31:24];
    if (a == 8'h80 && b[3]) m_tie = w[28];
  endtask
  task automatic mreset(bit glob);
    m_line = 8'hff;
    m_tie = 0;
    if (glob) begin
      m_sub = 0;
      m_mg = 8'h07;
      m_ml = 8'h04;
    end
  endtask
  task automatic load();
    logic [31:0] r;
    r = $urandom;
    @(posedge mclk);
    ld <= 1'b1;
    mgu <= 1'b1;
    esub <= r[15:0];
    eml <= r[23:16];
    mgv <= r[31:24];
    @(posedge mclk);
    ld <= 1'b0;
    mgu <= 1'b0;
    esub <= ~r[15:0];
    eml <= ~r[23:16];
    mgv <= ~r[31:24];
    m_sub = r[15:0];
    m_ml = r[23:16];
    m_mg = r[31:24];
  endtask
  task automatic conclude();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(32'h86a6));
    mreset(1'b1);
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (amap[i]) rdc(amap[i]);
    foreach (amap[i]) wrc(amap[i], 4'hf, 32'hffff_ffff);
    foreach (amap[i]) rdc(amap[i]);
    wrc(8'h3c, 4'h1, $urandom);
    rdc(8'h3c);
    load();
    rdc(8'h2c);
    rdc(8'h3c);
    wrc(8'h50, 4'hc, $urandom);
    rdc(8'h50);
    wrc(8'h50, 4'h3, $urandom);
    rdc(8'h2c);
    for (int t = 0; t < 32; t++) begin
      wrc(8'h80, 4'h8, {3'h0, t[4], 28'h0});
      @(posedge mclk);
      ties <= t[3] ? t[2:0] : 3'h0;
      sel <= t[1:0];
      rdc(8'h3c);
    end
    @(posedge mclk);
    ties <= 3'h0;
    sel <= 2'h0;
    func_rst <= 1'b1;
    @(posedge mclk);
    func_rst <= 1'b0;
    mreset(1'b0);
    rdc(8'h80);
    rdc(8'h2c);
    wrc(8'h3c, 4'h1, $urandom);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    mreset(1'b1);
    repeat (3) @(posedge mclk);
    rdc(8'h2c);
    rdc(8'h3c);
    conclude();
  end
endmodule // sccfg_header_regs_test
